/* File: shared/usdt_defines.vh */
/*
  Constants for the unipolar step/direction translator: register offsets,
  field positions, reset values and phase patterns.
  Assumes it is included by bare name from the design files that need it.
*/
`ifndef USDT_DEFINES_VH
`define USDT_DEFINES_VH

// Register offsets on the plain register port.
`define USDT_ADDR_W          4
`define USDT_DATA_W          8
`define USDT_OFS_STATUS      4'h0
`define USDT_OFS_POSITION    4'h1
`define USDT_OFS_STEP_COUNT  4'h2
`define USDT_OFS_CONTROL     4'h3

// Status register field positions.
`define USDT_ST_ORIGIN       0
`define USDT_ST_FAULT        1
`define USDT_ST_STANDBY      2
`define USDT_ST_HOLD         3
`define USDT_ST_HALF         4
`define USDT_ST_REVERSE      5
`define USDT_ST_DRIVING      6

// Control register field positions.
`define USDT_CTL_CNT_CLEAR   0

// Reset values.
`define USDT_POS_INIT        3'h0
`define USDT_CNT_INIT        8'h00
`define USDT_RDATA_IDLE      8'h00

// Translator step sizes in half-step positions.
`define USDT_STEP_HALF       3'h1
`define USDT_STEP_FULL       3'h2

// Phase patterns, bit order {coil1_pos, coil1_neg, coil2_pos, coil2_neg}.
`define USDT_PAT_P0          4'ha
`define USDT_PAT_P1          4'h2
`define USDT_PAT_P2          4'h6
`define USDT_PAT_P3          4'h4
`define USDT_PAT_P4          4'h5
`define USDT_PAT_P5          4'h1
`define USDT_PAT_P6          4'h9
`define USDT_PAT_P7          4'h8
`define USDT_PAT_OFF         4'h0

`endif

/* File: verilog/usdt_sync.v */
/*
  Two-stage synchroniser bank for asynchronous level inputs.
  Assumes the inputs come from pins outside the clock domain and that
  an undriven pin reads low, so both stages reset to zero.
*/
`timescale 1ns/1ps
`default_nettype none

module usdt_sync #(
  parameter WIDTH = 8
) (
  input  wire             clk_in,
  input  wire             rst_n_in,
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] stage1_q;
  reg [WIDTH-1:0] stage2_q;

  // The first stage feeds only the second, to keep metastability contained.
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stage1_q <= {WIDTH{1'b0}};
      stage2_q <= {WIDTH{1'b0}};
    end else begin
      stage1_q <= async_in;
      stage2_q <= stage1_q;
    end
  end

  assign sync_out = stage2_q;

endmodule

`default_nettype wire

/* File: verilog/usdt_top.v */
/*
  Step/direction translator for a two-phase unipolar stepper driver.
  It turns step edges into a four- or eight-state energizing sequence on
  four phase outputs, with origin and alarm flags and a status port.
  Assumes a free-running 50 MHz clock, an asynchronous active-low power-on
  reset, and that every control pin is asynchronous to the clock.
*/
// Local design decisions: the plain strobed port and the register offsets.
// Notes on behaviour
// - Each step rising edge advances one step.
// - Half-step select high means half-step mode.
// - Enable low forces outputs off, position kept.
// - Reset low: outputs off, translator initialized.
// - Standby low: initialize, outputs off, origin low.
// - Origin flag low exactly at initial position.
// - Protection trip: alarm low, outputs forced off.
// - After power-on: initial pattern, origin low.
// - Full-step forward four-state energizing sequence.
// - Full-step reverse four-state energizing sequence.
// - Half-step forward eight-state energizing sequence.
// - Half-step reverse eight-state energizing sequence.
// - Direction and mode captured at step edge.
// - Reset release restores initial energizing pattern.

`timescale 1ns/1ps
`default_nettype none
`include "usdt_defines.vh"

module usdt_top #(
  parameter CNT_W = 8
) (
  input  wire       REF_CLK_IN,
  input  wire       RESETN_IN,
  input  wire       STEP_IN,
  input  wire       ROTATION_SENSE_IN,
  input  wire       HALF_STEP_SELECT_IN,
  input  wire       OUTPUT_ENABLE_IN,
  input  wire       TRANSLATOR_RESETN_IN,
  input  wire       STANDBY_N_IN,
  input  wire       THERMAL_TRIP_IN,
  input  wire       UNDERVOLT_TRIP_IN,
  input  wire [3:0] REG_ADDR_IN,
  input  wire [7:0] REG_WDATA_IN,
  input  wire       REG_WR_IN,
  input  wire       REG_RD_IN,
  output wire [7:0] REG_RDATA_OUT,
  output wire       COIL1_POS_OUT,
  output wire       COIL1_NEG_OUT,
  output wire       COIL2_POS_OUT,
  output wire       COIL2_NEG_OUT,
  output wire       ORIGIN_FLAG_OUT,
  output wire       FAULT_FLAG_OUT,
  output wire       STANDBY_OUT
);

  // Operating states, one-hot.
  localparam [2:0] ST_STANDBY = 3'h1;
  localparam [2:0] ST_HOLD    = 3'h2;
  localparam [2:0] ST_RUN     = 3'h4;

  // Indices into the synchroniser bank.
  localparam IX_STEP  = 0;
  localparam IX_DIR   = 1;
  localparam IX_HALF  = 2;
  localparam IX_EN    = 3;
  localparam IX_RSTN  = 4;
  localparam IX_STBYN = 5;
  localparam IX_THERM = 6;
  localparam IX_UV    = 7;

  // Synchronised pin levels.
  wire [7:0] pins_async;
  wire [7:0] pins_sync;
  wire       s_step;
  wire       s_dir;
  wire       s_half;
  wire       s_en;
  wire       s_rstn;
  wire       s_stbyn;
  wire       s_trip;

  // Translator and bookkeeping state.
  reg              step_prev_q;
  reg  [2:0]       state_q;
  reg  [2:0]       state_d;
  reg  [2:0]       pos_q;
  reg  [2:0]       pos_d;
  reg              half_q;
  reg              half_d;
  reg              rev_q;
  reg              rev_d;
  reg  [CNT_W-1:0] cnt_q;
  reg  [CNT_W-1:0] cnt_d;
  wire             step_rise;
  wire             cnt_clear;
  wire             drive_on;

  // Registered outputs.
  reg [3:0] phase_q;
  reg [3:0] phase_d;
  reg       origin_q;
  reg       origin_d;
  reg       fault_q;
  reg       standby_q;
  reg [7:0] rdata_q;
  reg [7:0] rdata_d;

  // Next translator position: one position per half step, two per full
  // step, upward for forward and downward for reverse.
  // Wrap-around at eight comes for free from the three-bit arithmetic.
  function [2:0] next_pos;
    input [2:0] pos;
    input       reverse;
    input       half;
    reg   [2:0] delta;
    begin
      delta = half ? `USDT_STEP_HALF : `USDT_STEP_FULL;
      if (reverse) begin
        next_pos = pos - delta;
      end else begin
        next_pos = pos + delta;
      end
    end
  endfunction

  // Energizing pattern for each of the eight positions. From position 0, forward full
  // steps visit 2, 4, 6, 0 and reverse full steps 6, 4, 2, 0; half steps visit
  // every position in turn.
  // Unused codes cannot occur in three bits; the default only keeps the decode
  // complete.
  function [3:0] pattern;
    input [2:0] pos;
    begin
      case (pos)
        3'h0: pattern = `USDT_PAT_P0;
        3'h1: pattern = `USDT_PAT_P1;
        3'h2: pattern = `USDT_PAT_P2;
        3'h3: pattern = `USDT_PAT_P3;
        3'h4: pattern = `USDT_PAT_P4;
        3'h5: pattern = `USDT_PAT_P5;
        3'h6: pattern = `USDT_PAT_P6;
        3'h7: pattern = `USDT_PAT_P7;
        default: pattern = `USDT_PAT_OFF;
      endcase
    end
  endfunction

  // Every control pin is asynchronous, so all of them pass two flip-flops.
  // The price is three clocks from pin to phase output, far below the step
  // pulse width that a controller must give anyway.
  assign pins_async = {UNDERVOLT_TRIP_IN, THERMAL_TRIP_IN, STANDBY_N_IN,
                       TRANSLATOR_RESETN_IN, OUTPUT_ENABLE_IN,
                       HALF_STEP_SELECT_IN, ROTATION_SENSE_IN, STEP_IN};

  usdt_sync #(
    .WIDTH (8)
  ) u_sync (
    .clk_in   (REF_CLK_IN),
    .rst_n_in (RESETN_IN),
    .async_in (pins_async),
    .sync_out (pins_sync)
  );

  // Named views of the synchronised bank.
  assign s_step  = pins_sync[IX_STEP];
  assign s_dir   = pins_sync[IX_DIR];
  assign s_half  = pins_sync[IX_HALF];
  assign s_en    = pins_sync[IX_EN];
  assign s_rstn  = pins_sync[IX_RSTN];
  assign s_stbyn = pins_sync[IX_STBYN];
  assign s_trip  = pins_sync[IX_THERM] | pins_sync[IX_UV];

  // Only the low-to-high transition counts; falling edges and a step pin
  // that stays low do nothing.
  // The previous-level flop resets low, the idle level of the pin, so no false
  // edge follows reset.
  assign step_rise = s_step & ~step_prev_q;

  // Software clears the step counter by writing a one to the control bit.
  // The bit reads back as zero, so a read-modify-write cannot clear by accident.
  assign cnt_clear = REG_WR_IN & (REG_ADDR_IN == `USDT_OFS_CONTROL) &
                     REG_WDATA_IN[`USDT_CTL_CNT_CLEAR];

  // Standby outranks the reset pin, which outranks normal stepping.
  // A protection trip is not a state: it only gates the pins, so the translator
  // keeps its place and follows steps while the coils are off.
  always @* begin
    case (1'b1)
      ~s_stbyn: state_d = ST_STANDBY;
      ~s_rstn:  state_d = ST_HOLD;
      default:  state_d = ST_RUN;
    endcase
  end

  // Translator position. Direction and mode are sampled in the same cycle
  // that sees the step edge; the controller must hold them steady around
  // it, otherwise the step may go the wrong way.
  always @* begin
    pos_d  = pos_q;
    half_d = half_q;
    rev_d  = rev_q;
    case (state_d)
      ST_STANDBY: begin
        pos_d  = `USDT_POS_INIT;
        half_d = 1'b0;
        rev_d  = 1'b0;
      end
      ST_HOLD: begin
        pos_d = `USDT_POS_INIT;
      end
      ST_RUN: begin
        if (step_rise) begin
          half_d = s_half;
          rev_d  = s_dir;
          pos_d  = next_pos(pos_q, s_dir, s_half);
        end
      end
      default: begin
        pos_d = `USDT_POS_INIT;
      end
    endcase
  end

  // Count of accepted steps; a step in the clearing cycle is not lost.
  // The counter wraps at its width; software that needs more reads it in time.
  always @* begin
    cnt_d = cnt_q;
    if (cnt_clear) begin
      cnt_d = {CNT_W{1'b0}};
    end
    if ((state_d == ST_RUN) && step_rise) begin
      cnt_d = cnt_d + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // Phases drive only when stepping is allowed, enable is high and no
  // protection circuit has tripped. The translator itself keeps running
  // while enable is low, so re-enabling resumes at the same position.
  assign drive_on = (state_d == ST_RUN) & s_en & ~s_trip;

  // Output decode, computed from the next position so pins and position
  // change on the same edge.
  always @* begin
    if (drive_on) begin
      phase_d = pattern(pos_d);
    end else begin
      phase_d = `USDT_PAT_OFF;
    end
    if (state_d == ST_STANDBY) begin
      origin_d = 1'b0;
    end else begin
      origin_d = (pos_d != `USDT_POS_INIT);
    end
  end

  // Core state registers. Power-on reset leaves the translator at the
  // initial position.
  always @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      step_prev_q <= 1'b0;
      state_q     <= ST_HOLD;
      pos_q       <= `USDT_POS_INIT;
      half_q      <= 1'b0;
      rev_q       <= 1'b0;
      cnt_q       <= {CNT_W{1'b0}};
    end else begin
      step_prev_q <= s_step;
      state_q     <= state_d;
      pos_q       <= pos_d;
      half_q      <= half_d;
      rev_q       <= rev_d;
      cnt_q       <= cnt_d;
    end
  end

  // Pin registers. Phases start off until the synchronised pins show that
  // reset is released and enable is high; then the initial pattern shows.
  // The alarm follows the trip inputs directly, whatever the operating state.
  always @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      phase_q   <= `USDT_PAT_OFF;
      origin_q  <= 1'b0;
      fault_q   <= 1'b1;
      standby_q <= 1'b0;
    end else begin
      phase_q   <= phase_d;
      origin_q  <= origin_d;
      fault_q   <= ~s_trip;
      standby_q <= (state_d == ST_STANDBY);
    end
  end

  // Register read decode; unmapped offsets read as zero.
  // Reads have no side effects, so software may poll at any rate.
  always @* begin
    rdata_d = `USDT_RDATA_IDLE;
    if (REG_RD_IN) begin
      case (REG_ADDR_IN)
        `USDT_OFS_STATUS: begin
          rdata_d[`USDT_ST_ORIGIN]  = origin_q;
          rdata_d[`USDT_ST_FAULT]   = fault_q;
          rdata_d[`USDT_ST_STANDBY] = (state_q == ST_STANDBY);
          rdata_d[`USDT_ST_HOLD]    = (state_q == ST_HOLD);
          rdata_d[`USDT_ST_HALF]    = half_q;
          rdata_d[`USDT_ST_REVERSE] = rev_q;
          rdata_d[`USDT_ST_DRIVING] = (phase_q != `USDT_PAT_OFF);
        end
        `USDT_OFS_POSITION: begin
          rdata_d[2:0] = pos_q;
        end
        `USDT_OFS_STEP_COUNT: begin
          rdata_d = cnt_q[7:0];
        end
        default: begin
          rdata_d = `USDT_RDATA_IDLE;
        end
      endcase
    end
  end

  // Read data stands only in the cycle after the read strobe.
  // Between reads the port shows zero, which keeps stale data off it.
  always @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      rdata_q <= `USDT_RDATA_IDLE;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // All top-level outputs come straight from flip-flops.
  // Nothing combinational reaches a pin, so the coils never see decode glitches.
  assign COIL1_POS_OUT   = phase_q[3];
  assign COIL1_NEG_OUT   = phase_q[2];
  assign COIL2_POS_OUT   = phase_q[1];
  assign COIL2_NEG_OUT   = phase_q[0];
  assign ORIGIN_FLAG_OUT = origin_q;
  assign FAULT_FLAG_OUT  = fault_q;
  assign STANDBY_OUT     = standby_q;
  assign REG_RDATA_OUT   = rdata_q;

endmodule

`default_nettype wire

/* File: testbench/usdt_ctrl_model.sv */
/*
  Behavioural step/direction controller for the translator bench.
  Assumes a free-running bench clock; widths are counted in its cycles.
*/
`timescale 1ns/1ps
`default_nettype none

module usdt_ctrl_model (
  input  wire logic clk_in,
  output logic      step_out = 1'b0,
  output logic      dir_out = 1'b0,
  output logic      half_out = 1'b0
);
  // One step pulse; w sets both the pulse widths and the setup and hold of the levels.
  // Levels never move on the rising edge itself, or the step would be mis-read.
  task automatic move(input logic d, input logic h, input int w);
    @(posedge clk_in);
    dir_out <= d;
    half_out <= h;
    repeat (w) @(posedge clk_in);
    step_out <= 1'b1;
    repeat (w) @(posedge clk_in);
    step_out <= 1'b0;
    repeat (w) @(posedge clk_in);
  endtask
endmodule

`default_nettype wire

/* File: testbench/usdt_checker.sv */
/*
  Port-level assertions for the translator.
  Assumes pins pass two synchroniser flops and one output flop.
*/
`timescale 1ns/1ps
`default_nettype none

module usdt_checker (
  input wire logic REF_CLK_IN,
  input wire logic RESETN_IN,
  input wire logic STEP_IN,
  input wire logic OUTPUT_ENABLE_IN,
  input wire logic TRANSLATOR_RESETN_IN,
  input wire logic STANDBY_N_IN,
  input wire logic THERMAL_TRIP_IN,
  input wire logic UNDERVOLT_TRIP_IN,
  input wire logic COIL1_POS_OUT,
  input wire logic COIL1_NEG_OUT,
  input wire logic COIL2_POS_OUT,
  input wire logic COIL2_NEG_OUT,
  input wire logic ORIGIN_FLAG_OUT,
  input wire logic FAULT_FLAG_OUT,
  input wire logic STANDBY_OUT
);
  // Held conditions run four cycles, six for s_idle, so the pin pipeline has flushed first.
  wire [3:0] ph = {COIL1_POS_OUT, COIL1_NEG_OUT, COIL2_POS_OUT, COIL2_NEG_OUT};
  wire       trip = THERMAL_TRIP_IN | UNDERVOLT_TRIP_IN;
  wire       run = OUTPUT_ENABLE_IN & TRANSLATOR_RESETN_IN & STANDBY_N_IN & ~trip;

  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (!RESETN_IN);

  sequence s_trip;
    trip [*4];
  endsequence
  sequence s_idle;
    (run && $stable(STEP_IN)) [*6];
  endsequence
  sequence s_release;
    $rose(TRANSLATOR_RESETN_IN) ##0 (run && !STEP_IN) [*4];
  endsequence

  AST_TRIP_OFF: assert property (s_trip |=> !FAULT_FLAG_OUT && ph == 4'h0)
    else $error("phases or alarm wrong during trip");
  AST_FAULT_HIGH: assert property ((!trip) [*4] |=> FAULT_FLAG_OUT)
    else $error("alarm low without trip");
  AST_OE_OFF: assert property ((!OUTPUT_ENABLE_IN) [*4] |=> ph == 4'h0)
    else $error("phases on while disabled");
  AST_TRESET_OFF: assert property ((!TRANSLATOR_RESETN_IN) [*4] |=>
    ph == 4'h0 && !ORIGIN_FLAG_OUT)
    else $error("phases or origin wrong in reset");
  AST_STANDBY: assert property ((!STANDBY_N_IN) [*4] |=>
    ph == 4'h0 && !ORIGIN_FLAG_OUT && STANDBY_OUT)
    else $error("standby outputs wrong");
  AST_ORIGIN: assert property (run [*4] |=> ORIGIN_FLAG_OUT == (ph != 4'ha))
    else $error("origin flag disagrees with pattern");
  AST_STILL: assert property (s_idle |=> $stable(ph) && $stable(ORIGIN_FLAG_OUT))
    else $error("pattern moved without step edge");
  AST_RELEASE: assert property (s_release |=> ph == 4'ha && !ORIGIN_FLAG_OUT)
    else $error("no initial pattern after reset release");
endmodule

`default_nettype wire

/* File: testbench/usdt_top_tb.sv */
/*
  Self-checking bench for the step/direction translator.
  Assumes the controller model drives the step pins; the checker is bound below.
*/
`timescale 1ns/1ps
`default_nettype none

module usdt_top_tb;
  logic       clk = 1'b0;
  logic       rstn = 1'b0;
  logic       oe = 1'b1, trn = 1'b1, sbn = 1'b1, thr = 1'b0, uv = 1'b0;
  logic       wr = 1'b0, rd = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] d;
  logic [2:0] pos = 3'h0;
  wire        stp, dir, half, c1p, c1n, c2p, c2n, org, flt, sby;
  wire  [7:0] rdata;
  int         errors = 0;
  int         n_compared = 0;
  // Coil pattern per translator position, {c1p, c1n, c2p, c2n}.
  logic [3:0] pats [8] = '{4'ha, 4'h2, 4'h6, 4'h4, 4'h5, 4'h1, 4'h9, 4'h8};

  always #10 clk = ~clk;

  usdt_ctrl_model u_usdt_ctrl_model (
    .clk_in(clk), .step_out(stp), .dir_out(dir), .half_out(half)
  );
  usdt_top u_usdt_top (
    .REF_CLK_IN(clk), .RESETN_IN(rstn), .STEP_IN(stp), .ROTATION_SENSE_IN(dir),
    .HALF_STEP_SELECT_IN(half), .OUTPUT_ENABLE_IN(oe), .TRANSLATOR_RESETN_IN(trn),
    .STANDBY_N_IN(sbn), .THERMAL_TRIP_IN(thr), .UNDERVOLT_TRIP_IN(uv),
    .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd),
    .REG_RDATA_OUT(rdata), .COIL1_POS_OUT(c1p), .COIL1_NEG_OUT(c1n),
    .COIL2_POS_OUT(c2p), .COIL2_NEG_OUT(c2n), .ORIGIN_FLAG_OUT(org),
    .FAULT_FLAG_OUT(flt), .STANDBY_OUT(sby)
  );

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic chk_out(input logic [3:0] e, input logic o, input logic f);
    chk({2'h0, flt, org, c1p, c1n, c2p, c2n}, {2'h0, f, o, e});
  endtask

  // A pin change reaches the outputs three edges later; one more edge gives margin.
  task automatic settle;
    repeat (4) @(posedge clk);
    #1;
  endtask

  task automatic wreg(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rreg(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic tally_and_finish;
    $display("errors=%0d compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Main sequence: every mode and direction, then the register port and the control pins.
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    settle();
    chk_out(4'ha, 1'b0, 1'b1);
    for (int m = 0; m < 4; m++) begin
      for (int s = 0; s < (m[1] ? 8 : 4); s++) begin
        u_usdt_ctrl_model.move(m[0], m[1], m[0] ? 5 : 2);
        if (m[0])
          pos = pos - (m[1] ? 3'h1 : 3'h2);
        else
          pos = pos + (m[1] ? 3'h1 : 3'h2);
        settle();
        chk_out(pats[pos], pos != 3'h0, 1'b1);
      end
    end
    rreg(4'h2, d);
    chk(d, 8'h18);
    rreg(4'h0, d);
    chk(d, 8'h72);
    wreg(4'h3, 8'h01);
    rreg(4'h2, d);
    chk(d, 8'h00);
    rreg(4'hf, d);
    chk(d, 8'h00);
    @(posedge clk);
    oe <= 1'b0;
    u_usdt_ctrl_model.move(1'b0, 1'b0, 2);
    pos = 3'h2;
    settle();
    chk_out(4'h0, 1'b1, 1'b1);
    rreg(4'h1, d);
    chk(d, {5'h00, pos});
    @(posedge clk);
    oe <= 1'b1;
    settle();
    chk_out(pats[pos], 1'b1, 1'b1);
    for (int t = 0; t < 2; t++) begin
      @(posedge clk);
      thr <= (t == 0);
      uv <= (t == 1);
      settle();
      chk_out(4'h0, 1'b1, 1'b0);
      @(posedge clk);
      thr <= 1'b0;
      uv <= 1'b0;
      settle();
      chk_out(pats[pos], 1'b1, 1'b1);
    end
    @(posedge clk);
    trn <= 1'b0;
    settle();
    chk_out(4'h0, 1'b0, 1'b1);
    u_usdt_ctrl_model.move(1'b0, 1'b0, 2);
    settle();
    chk_out(4'h0, 1'b0, 1'b1);
    rreg(4'h0, d);
    chk(d, 8'h0a);
    @(posedge clk);
    trn <= 1'b1;
    pos = 3'h0;
    settle();
    chk_out(4'ha, 1'b0, 1'b1);
    u_usdt_ctrl_model.move(1'b0, 1'b1, 2);
    pos = pos + 3'h1;
    settle();
    chk_out(pats[pos], 1'b1, 1'b1);
    @(posedge clk);
    sbn <= 1'b0;
    settle();
    chk_out(4'h0, 1'b0, 1'b1);
    chk({7'h00, sby}, 8'h01);
    rreg(4'h0, d);
    chk(d, 8'h06);
    @(posedge clk);
    sbn <= 1'b1;
    settle();
    chk_out(4'ha, 1'b0, 1'b1);
    tally_and_finish();
  end

  // The tests need about 500 cycles; the watchdog allows twenty times that.
  initial begin
    #200000;
    errors++;
    tally_and_finish();
  end
endmodule

bind usdt_top usdt_checker u_usdt_checker (.*);

`default_nettype wire
